/* fps_consts.vh */
`ifndef FPS_CONSTS_VH
`define FPS_CONSTS_VH

// software register byte offsets
`define FPS_OFF_CMD    8'h00
`define FPS_OFF_ADDR   8'h04
`define FPS_OFF_LEN    8'h08
`define FPS_OFF_DATA   8'h0C
`define FPS_OFF_PTR    8'h10
`define FPS_OFF_STAT   8'h14
`define FPS_OFF_CFG    8'h18

// operation codes written to the command register
`define FPS_OP_WRITE_ENABLE_CMD    3'h0
`define FPS_OP_PP      3'h1
`define FPS_OP_QPP     3'h2
`define FPS_OP_SUSP    3'h3
`define FPS_OP_RESUME  3'h4
`define FPS_OP_RDSR    3'h5
`define FPS_OP_SIDR    3'h6
`define FPS_OP_SIDP    3'h7

// flash opcodes
`define FPS_OPC_WRITE_ENABLE_CMD   8'h06
`define FPS_OPC_PP     8'h02
`define FPS_OPC_QPP    8'h32
`define FPS_OPC_SUSP   8'hB0
`define FPS_OPC_RESUME 8'h30
`define FPS_OPC_RDSR   8'h05
`define FPS_OPC_SIDR   8'h88
`define FPS_OPC_SIDP   8'hA5

// field positions
`define FPS_CFG_QUAD_BIT   0
`define FPS_STAT_BUSY_BIT  0
`define FPS_STAT_ERR_BIT   1
`define FPS_STAT_GAP_BIT   2
`define FPS_STAT_LAT_BIT   3
`define FPS_STAT_DEV_LSB   8

// reset values
`define FPS_CFG_RST    1'h0
`define FPS_LEN_RST    9'h001

// page and identifier space limits
`define FPS_PAGE_BYTES 9'h100
`define FPS_SID_USER_LO 24'h000008
`define FPS_SID_END    24'h000800
`define FPS_SID_DUMMY  9'h001

// timing in core_clk cycles at 40 MHz: 500 us spacing, 25 us latency
`define FPS_SUSP_GAP_CYC   16'h4E20
`define FPS_SUSP_LAT_CYC   16'h03E8
`define FPS_SCK_HALF_CYC   3'h4
`define FPS_CS_HIGH_CYC    4'h4

`endif

/* fps_shift.v */
`include "fps_consts.vh"

module fps_shift (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire start,
  input wire quad,
  input wire sel,
  input wire [7:0] tx_byte,
  input wire [3:0] io_in,
  output wire busy,
  output reg done,
  output reg [7:0] rx_byte,
  output reg sck,
  output wire [3:0] io_out,
  output wire [3:0] io_oe
);
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg act_q;
  reg quad_q;
  reg [2:0] div_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  wire tick;

  assign busy = act_q;
  assign tick = act_q && (div_q == (`FPS_SCK_HALF_CYC - 3'h1));
  // msb first on io0 in single mode, upper nibble first in quad mode
  assign io_out = quad_q ? sh_q[7:4] : {3'h0, sh_q[7]};
  assign io_oe = sel ? (quad_q ? 4'hF : 4'h1) : 4'h0;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else if (clk_en) begin
      sync1_q <= io_in;
      sync2_q <= sync1_q;
    end
  end

  // mode 0: data changes on the falling edge, both ends sample on rising.
  // the device data settles a half period before our rising edge, which
  // covers the two-stage synchroniser delay.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      act_q <= 1'b0;
      quad_q <= 1'b0;
      div_q <= 3'h0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rx_byte <= 8'h00;
      sck <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start && !act_q) begin
        act_q <= 1'b1;
        quad_q <= quad;
        sh_q <= tx_byte;
        cnt_q <= quad ? 4'h2 : 4'h8;
        div_q <= 3'h0;
        sck <= 1'b0;
      end else if (act_q) begin
        div_q <= tick ? 3'h0 : div_q + 3'h1;
        if (tick) begin
          sck <= ~sck;
          if (!sck) begin
            rx_byte <= quad_q ? {rx_byte[3:0], sync2_q} :
                                {rx_byte[6:0], sync2_q[1]};
          end else begin
            sh_q <= quad_q ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
              act_q <= 1'b0;
              done <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule

/* fps_host.v */
// What this block does
// - page program frame is select, 02H, three address bytes, data.
// - data length is 1 to 256 whole bytes; longer is refused with error.
// - write enable goes out before every program command.
// - quad page program uses 32H, three address bytes and data.
// - quad opcode takes eight clocks on one line, rest two on four.
// - quad config bit must be set before quad page program.
// - at least 500 us between successive suspend commands.
// - suspend is B0H alone; only status read 05H until latency passes.
// - resume is B0H's partner 30H, sent alone in one selection.
// - identifier read is 88H, two address bytes, one dummy byte.
// - identifier program is A5H, two address bytes, 1 to 256 bytes.
// - status read 05H is allowed at any time, even mid write.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`include "fps_consts.vh"

module fps_host #(
  parameter [15:0] SUSP_GAP_CYC = `FPS_SUSP_GAP_CYC,
  parameter [15:0] SUSP_LAT_CYC = `FPS_SUSP_LAT_CYC
) (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  output reg [31:0] reg_rdata,
  output reg flash_cs_n,
  output wire flash_sck,
  input wire [3:0] flash_io_in,
  output wire [3:0] flash_io_out,
  output wire [3:0] flash_io_oe
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SEL = 3'h1;
  localparam [2:0] S_OPC = 3'h2;
  localparam [2:0] S_ADR = 3'h3;
  localparam [2:0] S_DUM = 3'h4;
  localparam [2:0] S_WR = 3'h5;
  localparam [2:0] S_RD = 3'h6;
  localparam [2:0] S_DESEL = 3'h7;

  reg [7:0] buf_mem [0:255];
  reg [2:0] state_q;
  reg [2:0] op_q;
  reg write_enable_cmd_ph_q;
  reg [23:0] addr_q;
  reg [8:0] len_q;
  reg [8:0] cnt_q;
  reg [23:0] adr_sh_q;
  reg [7:0] idx_q;
  reg [7:0] ptr_q;
  reg [3:0] gap_q;
  reg run_q;
  reg err_q;
  reg [7:0] dev_stat_q;
  reg [15:0] susp_gap_q;
  reg [15:0] susp_lat_q;
  reg cfg_quad_q;

  reg [7:0] opc;
  reg [1:0] abytes;
  reg has_dum;
  reg is_wr;
  reg is_rd;
  reg needs_write_enable_cmd;
  reg len_ok;
  reg cmd_ok;
  reg [7:0] tx_byte;
  wire [2:0] new_op;
  wire byte_state;
  wire sh_start;
  wire sh_busy;
  wire sh_done;
  wire sh_quad;
  wire [7:0] rx_byte;
  wire cmd_wr;

  assign new_op = reg_wdata[2:0];
  assign cmd_wr = reg_we && (reg_addr == `FPS_OFF_CMD);
  assign byte_state = (state_q >= S_OPC) && (state_q <= S_RD);
  assign sh_start = byte_state && !run_q && !sh_busy;
  // opcode always single wire, quad only for address and data bytes
  assign sh_quad = (op_q == `FPS_OP_QPP) && !write_enable_cmd_ph_q &&
                   ((state_q == S_ADR) || (state_q == S_WR));

  // frame shape of the running operation
  always @* begin
    opc = `FPS_OPC_RDSR;
    abytes = 2'd0;
    has_dum = 1'b0;
    is_wr = 1'b0;
    is_rd = 1'b0;
    case (op_q)
      `FPS_OP_WRITE_ENABLE_CMD: opc = `FPS_OPC_WRITE_ENABLE_CMD;
      `FPS_OP_PP: begin
        opc = `FPS_OPC_PP;
        abytes = 2'd3;
        is_wr = 1'b1;
      end
      `FPS_OP_QPP: begin
        opc = `FPS_OPC_QPP;
        abytes = 2'd3;
        is_wr = 1'b1;
      end
      `FPS_OP_SUSP: opc = `FPS_OPC_SUSP;
      `FPS_OP_RESUME: opc = `FPS_OPC_RESUME;
      `FPS_OP_RDSR: begin
        opc = `FPS_OPC_RDSR;
        is_rd = 1'b1;
      end
      `FPS_OP_SIDR: begin
        opc = `FPS_OPC_SIDR;
        abytes = 2'd2;
        has_dum = 1'b1;
        is_rd = 1'b1;
      end
      `FPS_OP_SIDP: begin
        opc = `FPS_OPC_SIDP;
        abytes = 2'd2;
        is_wr = 1'b1;
      end
      default: opc = `FPS_OPC_RDSR;
    endcase
  end

  // admission check for a command written by software
  always @* begin
    len_ok = (len_q != 9'h000) && (len_q <= `FPS_PAGE_BYTES);
    needs_write_enable_cmd = (new_op == `FPS_OP_PP) || (new_op == `FPS_OP_QPP) ||
                 (new_op == `FPS_OP_SIDP);
    cmd_ok = 1'b1;
    case (new_op)
      `FPS_OP_PP: cmd_ok = len_ok;
      `FPS_OP_QPP: cmd_ok = len_ok && cfg_quad_q;
      `FPS_OP_SUSP: cmd_ok = (susp_gap_q == 16'h0000);
      `FPS_OP_SIDR: cmd_ok = len_ok && (addr_q < `FPS_SID_END);
      `FPS_OP_SIDP: cmd_ok = len_ok && (addr_q >= `FPS_SID_USER_LO) &&
                             (addr_q < `FPS_SID_END);
      default: cmd_ok = 1'b1;
    endcase
    // after a suspend only status reads may go out until the latency ends
    if ((susp_lat_q != 16'h0000) && (new_op != `FPS_OP_RDSR)) begin
      cmd_ok = 1'b0;
    end
  end

  always @* begin
    case (state_q)
      S_OPC: tx_byte = write_enable_cmd_ph_q ? `FPS_OPC_WRITE_ENABLE_CMD : opc;
      S_ADR: tx_byte = adr_sh_q[23:16];
      S_WR: tx_byte = buf_mem[idx_q];
      default: tx_byte = 8'h00;
    endcase
  end

  // buffer: software fills it while idle, the sequencer stores read data
  always @(posedge core_clk) begin
    if (clk_en) begin
      if (state_q == S_RD && sh_done && op_q != `FPS_OP_RDSR) begin
        buf_mem[idx_q] <= rx_byte;
      end else if (reg_we && reg_addr == `FPS_OFF_DATA &&
                   state_q == S_IDLE) begin
        buf_mem[ptr_q] <= reg_wdata[7:0];
      end
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= 24'h000000;
      len_q <= `FPS_LEN_RST;
      ptr_q <= 8'h00;
      cfg_quad_q <= `FPS_CFG_RST;
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      reg_rdata <= 32'h00000000;
      if (reg_we && state_q == S_IDLE) begin
        case (reg_addr)
          `FPS_OFF_ADDR: addr_q <= reg_wdata[23:0];
          `FPS_OFF_LEN: len_q <= reg_wdata[8:0];
          `FPS_OFF_PTR: ptr_q <= reg_wdata[7:0];
          `FPS_OFF_DATA: ptr_q <= ptr_q + 8'h01;
          `FPS_OFF_CFG: cfg_quad_q <= reg_wdata[`FPS_CFG_QUAD_BIT];
          default: ptr_q <= ptr_q;
        endcase
      end else if (reg_re) begin
        case (reg_addr)
          `FPS_OFF_CMD: reg_rdata <= {29'h0, op_q};
          `FPS_OFF_ADDR: reg_rdata <= {8'h00, addr_q};
          `FPS_OFF_LEN: reg_rdata <= {23'h0, len_q};
          `FPS_OFF_DATA: begin
            reg_rdata <= {24'h0, buf_mem[ptr_q]};
            ptr_q <= ptr_q + 8'h01;
          end
          `FPS_OFF_PTR: reg_rdata <= {24'h0, ptr_q};
          `FPS_OFF_STAT: reg_rdata <= {16'h0, dev_stat_q, 4'h0,
                                       susp_lat_q != 16'h0000,
                                       susp_gap_q != 16'h0000,
                                       err_q, state_q != S_IDLE};
          `FPS_OFF_CFG: reg_rdata <= {31'h0, cfg_quad_q};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      op_q <= `FPS_OP_WRITE_ENABLE_CMD;
      write_enable_cmd_ph_q <= 1'b0;
      cnt_q <= 9'h000;
      adr_sh_q <= 24'h000000;
      idx_q <= 8'h00;
      gap_q <= 4'h0;
      run_q <= 1'b0;
      err_q <= 1'b0;
      dev_stat_q <= 8'h00;
      susp_gap_q <= 16'h0000;
      susp_lat_q <= 16'h0000;
      flash_cs_n <= 1'b1;
    end else if (clk_en) begin
      if (susp_gap_q != 16'h0000) susp_gap_q <= susp_gap_q - 16'h0001;
      if (susp_lat_q != 16'h0000) susp_lat_q <= susp_lat_q - 16'h0001;
      if (sh_start) run_q <= 1'b1;
      else if (sh_done) run_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (cmd_wr) begin
            err_q <= ~cmd_ok;
            if (cmd_ok) begin
              op_q <= new_op;
              write_enable_cmd_ph_q <= needs_write_enable_cmd;
              state_q <= S_SEL;
              flash_cs_n <= 1'b0;
            end
          end
        end
        S_SEL: begin
          idx_q <= 8'h00;
          adr_sh_q <= (abytes == 2'd2) ? {addr_q[15:0], 8'h00} : addr_q;
          state_q <= S_OPC;
        end
        S_OPC: begin
          if (sh_done) begin
            if (write_enable_cmd_ph_q || (abytes == 2'd0 && !is_rd)) begin
              state_q <= S_DESEL;
              flash_cs_n <= 1'b1;
            end else if (abytes != 2'd0) begin
              state_q <= S_ADR;
              cnt_q <= {7'h00, abytes};
            end else begin
              state_q <= S_RD;
              cnt_q <= 9'h001;
            end
          end
        end
        S_ADR: begin
          if (sh_done) begin
            adr_sh_q <= {adr_sh_q[15:0], 8'h00};
            cnt_q <= cnt_q - 9'h001;
            if (cnt_q == 9'h001) begin
              if (has_dum) begin
                state_q <= S_DUM;
                cnt_q <= `FPS_SID_DUMMY;
              end else begin
                state_q <= is_wr ? S_WR : S_RD;
                cnt_q <= len_q;
              end
            end
          end
        end
        S_DUM: begin
          if (sh_done) begin
            cnt_q <= cnt_q - 9'h001;
            if (cnt_q == 9'h001) begin
              state_q <= S_RD;
              cnt_q <= len_q;
            end
          end
        end
        S_WR, S_RD: begin
          if (sh_done) begin
            if (op_q == `FPS_OP_RDSR) dev_stat_q <= rx_byte;
            idx_q <= idx_q + 8'h01;
            cnt_q <= cnt_q - 9'h001;
            // whole bytes only; deselect ends the frame
            if (cnt_q == 9'h001) begin
              state_q <= S_DESEL;
              flash_cs_n <= 1'b1;
            end
          end
        end
        S_DESEL: begin
          if (gap_q == `FPS_CS_HIGH_CYC) begin
            gap_q <= 4'h0;
            if (write_enable_cmd_ph_q) begin
              write_enable_cmd_ph_q <= 1'b0;
              state_q <= S_SEL;
              flash_cs_n <= 1'b0;
            end else begin
              state_q <= S_IDLE;
              if (op_q == `FPS_OP_SUSP) begin
                susp_gap_q <= SUSP_GAP_CYC;
                susp_lat_q <= SUSP_LAT_CYC;
              end
            end
          end else begin
            gap_q <= gap_q + 4'h1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  fps_shift u_shift (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .start(sh_start),
    .quad(sh_quad),
    .sel(~flash_cs_n),
    .tx_byte(tx_byte),
    .io_in(flash_io_in),
    .busy(sh_busy),
    .done(sh_done),
    .rx_byte(rx_byte),
    .sck(flash_sck),
    .io_out(flash_io_out),
    .io_oe(flash_io_oe)
  );
endmodule

/* fps_host_properties.sv */
module fps_host_properties (
  input wire core_clk,
  input wire resetn,
  input wire reg_re,
  input wire [31:0] reg_rdata,
  input wire flash_cs_n,
  input wire flash_sck,
  input wire [3:0] flash_io_out,
  input wire [3:0] flash_io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_high;
    flash_sck [*4] ##1 !flash_sck;
  endsequence
  sequence s_low;
    (!flash_sck) [*4];
  endsequence
  sequence s_gap;
    flash_cs_n [*5];
  endsequence
  AST_SCK_IDLE: assert property (flash_cs_n |-> !flash_sck)
    else $error("sck active while deselected");
  AST_SCK_HIGH: assert property ($rose(flash_sck) |-> s_high)
    else $error("sck high phase wrong");
  AST_SCK_LOW: assert property ($fell(flash_sck) |-> s_low)
    else $error("sck low phase short");
  AST_CS_GAP: assert property ($rose(flash_cs_n) |-> s_gap)
    else $error("select gap short");
  AST_CS_EDGE: assert property ($changed(flash_cs_n)
    |-> !flash_sck && !$past(flash_sck))
    else $error("select moved with sck high");
  AST_IO_HOLD: assert property (flash_sck && $past(flash_sck)
    |-> $stable(flash_io_out) && $stable(flash_io_oe))
    else $error("data moved with sck high");
  AST_OE_MODE: assert property (!flash_cs_n
    |-> flash_io_oe inside {4'h0, 4'h1, 4'hF})
    else $error("bad lane enable");
  AST_RD_ZERO: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
endmodule

bind fps_host fps_host_properties chk (.core_clk(core_clk), .resetn(resetn),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .flash_cs_n(flash_cs_n),
  .flash_sck(flash_sck), .flash_io_out(flash_io_out),
  .flash_io_oe(flash_io_oe));

/* fps_flash_model.sv */
module fps_flash_model #(
  parameter int PROG_T = 400,
  parameter logic [7:0] PROT_HI = 8'h3F
) (
  input wire cs_n,
  input wire sck,
  input wire [3:0] io_oe,
  input wire [3:0] io_out,
  output wire [3:0] line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic [7:0] security_identifier [2048];
  logic [7:0] op;
  logic [7:0] sh;
  logic [7:0] ob;
  logic [23:0] a;
  logic [11:0] sec;
  logic [3:0] drv = 4'h5;
  logic wel = 1'h0;
  logic sus = 1'h0;
  logic ers = 1'h0;
  logic ce = 1'h0;
  int n = 0;
  int rem = 0;
  int srem = 0;
  // status layout is a model choice: program suspended, erase suspended,
  // write latch, busy; srem times a write begun during a suspension
  wire [7:0] sr = {4'h0, sus && !ers, sus && ers, wel,
                   (rem > 0 && !sus) || srem > 0};
  // a released line flips level so a stale value cannot pass as data
  assign line = (io_oe & io_out) | (~io_oe & drv);
  initial begin
    for (int i = 0; i < 2048; i++)
      security_identifier[i] = i < 8 ? 8'(i) : 8'hFF;
  end
  always #100 begin
    if (srem > 0)
      srem--;
    else if (rem > 0 && !sus)
      rem--;
    if (rem == 0)
      ce = 1'h0;
  end
  always @(negedge cs_n)
    n = 0;
  always @(posedge cs_n) begin
    if (wel && n > 24 && !refused() && (op == 8'h02 || op == 8'h32 ||
        op == 8'hA5 || op == 8'h20)) begin
      if (rem == 0) begin
        rem = PROG_T;
        ers = op == 8'h20;
        sec = a[23:12];
      end else if (sus && srem == 0) begin
        srem = PROG_T;
      end
      wel = 1'h0;
    end
    // no chip erase while a write is suspended
    if (wel && n == 8 && op == 8'hC7 && rem == 0 && !sus) begin
      rem = PROG_T;
      ce = 1'h1;
      wel = 1'h0;
    end
    drv = ~drv;
  end
  always @(posedge sck) begin
    if (!cs_n) begin
      if (op == 8'h32 && n >= 8) begin
        sh = {sh[3:0], line};
        n += 4;
      end else begin
        sh = {sh[6:0], line[0]};
        n += 1;
      end
      if (n % 8 == 0)
        take(n / 8);
    end
  end
  always @(negedge sck) begin
    if (!cs_n) begin
      drv[1] = ob[7];
      ob = ob << 1;
    end
  end
  task automatic take(input int k);
    if (k == 1) begin
      op = sh;
      if (op == 8'h06)
        wel = 1'h1;
      if (op == 8'hB0 && rem > 0 && !sus && !ce)
        sus = 1'h1;
      if (op == 8'h30 && srem == 0)
        sus = 1'h0;
    end else if (k < ((op == 8'h88 || op == 8'hA5) ? 4 : 5)) begin
      a = {a[15:0], sh};
    end else if (wel && !refused() && (op == 8'h02 || op == 8'h32)) begin
      mem[8'(a[7:0] + k - 5)] = sh;
    end else if (wel && op == 8'hA5 && a[15:0] >= 16'h8
                 && a[15:0] < 16'h800) begin
      security_identifier[{a[10:8], 8'(a[7:0] + k - 4)}] = sh;
    end
    if (op == 8'h05 || (op == 8'h88 && k > 3))
      ob = op == 8'h05 ? sr : security_identifier[11'(a[15:0] + k - 4)];
  endtask
  // refused: a protected area, or a clash with the suspended sector when either side is an erase
  function automatic logic refused();
    logic clash;
    clash = sus && a[23:12] == sec;
    return (a[23:16] == PROT_HI && op != 8'hA5) ||
      (clash && ers) ||
      (clash && op == 8'h20);
  endfunction
endmodule

/* fps_host_bench.sv */
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  fails++; $display("ERROR %0t got %h", $time, a); end end
module fps_host_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic reg_we = 1'h0;
  logic reg_re = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] v;
  logic [8:0] bad [2] = '{9'h000, 9'h101};
  logic [7:0] sid_exp [3] = '{8'h06, 8'h07, 8'h3C};
  wire [31:0] reg_rdata;
  wire flash_cs_n;
  wire flash_sck;
  wire [3:0] line;
  wire [3:0] io_out;
  wire [3:0] io_oe;
  int fails = 0;
  int check_count = 0;
  always #12.5 core_clk = ~core_clk;
  fps_host #(.SUSP_GAP_CYC(16'h28), .SUSP_LAT_CYC(16'h14)) uut (
    .core_clk(core_clk), .resetn(resetn), .clk_en(1'h1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .flash_cs_n(flash_cs_n),
    .flash_sck(flash_sck), .flash_io_in(line), .flash_io_out(io_out),
    .flash_io_oe(io_oe));
  fps_flash_model fm (.cs_n(flash_cs_n), .sck(flash_sck), .io_oe(io_oe),
    .io_out(io_out), .line(line));
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'h1;
    @(posedge core_clk);
    reg_we <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'h1;
    @(posedge core_clk);
    reg_re <= 1'h0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
  task cmd(input logic [2:0] op);
    wr(8'h00, {29'h0, op});
    for (int i = 0; i < 3000; i++) begin
      rd(8'h14);
      if (v[0] === 1'h0)
        return;
    end
    fails++;
    give_verdict;
  endtask
  task dev_idle;
    for (int i = 0; i < 200; i++) begin
      cmd(3'h5);
      rd(8'h14);
      if (v[8] === 1'h0)
        return;
    end
    fails++;
    give_verdict;
  endtask
  task setup(input logic [23:0] a, input logic [8:0] n, input logic [7:0] d0,
             input logic [7:0] d1);
    wr(8'h04, {8'h0, a});
    wr(8'h08, {23'h0, n});
    wr(8'h10, 32'h0);
    wr(8'h0C, {24'h0, d0});
    wr(8'h0C, {24'h0, d1});
    wr(8'h10, 32'h0);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'h1;
    rd(8'h08);
    `CHK(v, 32'h1)
    rd(8'h40);
    `CHK(v, 32'h0)
    setup(24'h0000FF, 9'h002, 8'hA5, 8'h3C);
    cmd(3'h1);
    cmd(3'h5);
    rd(8'h14);
    `CHK(v[8], 1'h1)
    `CHK(fm.mem[8'hFF], 8'hA5)
    `CHK(fm.mem[8'h00], 8'h3C)
    $display("program test done");
    cmd(3'h3);
    cmd(3'h4);
    rd(8'h14);
    `CHK(v[3:1], 3'h7)
    repeat (25) @(posedge core_clk);
    cmd(3'h3);
    rd(8'h14);
    `CHK(v[1], 1'h1)
    repeat (45) @(posedge core_clk);
    cmd(3'h5);
    rd(8'h14);
    `CHK(v[11:8], 4'h8)
    cmd(3'h4);
    cmd(3'h5);
    rd(8'h14);
    `CHK(v[11:8], 4'h1)
    dev_idle;
    $display("suspend test done");
    setup(24'h000010, 9'h002, 8'h5A, 8'hC3);
    cmd(3'h2);
    rd(8'h14);
    `CHK(v[1], 1'h1)
    wr(8'h18, 32'h1);
    cmd(3'h2);
    dev_idle;
    `CHK(fm.mem[8'h10], 8'h5A)
    `CHK(fm.mem[8'h11], 8'hC3)
    foreach (bad[i]) begin
      wr(8'h08, {23'h0, bad[i]});
      cmd(3'h1);
      rd(8'h14);
      `CHK(v[1], 1'h1)
    end
    $display("quad and length test done");
    setup(24'h000007, 9'h001, 8'h3C, 8'h00);
    cmd(3'h7);
    rd(8'h14);
    `CHK(v[1], 1'h1)
    wr(8'h04, 32'h8);
    cmd(3'h7);
    dev_idle;
    `CHK(fm.security_identifier[8], 8'h3C)
    setup(24'h000006, 9'h003, 8'h00, 8'h00);
    cmd(3'h6);
    for (int i = 0; i < 3; i++) begin
      rd(8'h0C);
      `CHK(v[7:0], sid_exp[i])
    end
    $display("identifier test done");
    cmd(3'h0);
    cmd(3'h5);
    rd(8'h14);
    `CHK(v[9], 1'h1)
    $display("write enable test done");
    give_verdict;
  end
endmodule
